// ==== hw/charger_profile_config_regs.sv ====
// charger temperature profile, adders, limits and phase timers
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
// Function
// - threshold 0x20 divides regions 3 and 2, reset 0x372A
// - threshold 0x21 divides regions 4 and 3, reset 0x1F27
// - threshold 0x22 divides regions 5 and 4, reset 0x1BCC
// - threshold 0x23 divides regions 6 and 5, reset 0x18B9
// - threshold 0x24 divides regions 7 and 6; region 7 is off
// - voltage codes region 6 bits 9:5, region 5 bits 4:0
// - voltage codes region 4 at 14:10, 3 at 9:5, 2 at 4:0
// - current targets regions 6,5 reset 0x0F each, register 0x01EF
// - current targets regions 4,3,2 reset 0x1F,0x1F,0x0F, total 0x7FEF
// - enables: bit2 low-current stop, bit1 lead temp comp, bit0 profile
// - absorb voltage adder six bits 5:0, upper bits reserved
// - equalize voltage adder six bits 5:0, reset 0x002A
// - read-only seconds counter of lithium total charging time
// - read-only seconds counter of non-lithium absorb phase time
// - count constant-voltage seconds; lithium stops at set limit
module charger_profile_config_regs
  import charger_profile_pkg::*;
#(
  parameter int SEC_CNT = SEC_CYCLES
) (
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [15:0]       ntc_ratio_i,
  input  wire logic              lithium_i,
  input  wire logic              charging_i,
  input  wire logic              cv_i,
  input  wire logic              absorb_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic      [2:0]        region_o,
  output logic                   charge_off_o,
  output logic      [4:0]        vcharge_code_o,
  output logic      [4:0]        icharge_code_o,
  output logic                   cx_term_en_o,
  output logic                   lead_temp_comp_o,
  output logic                   cv_limit_stop_o
);
  if (SEC_CNT < 2) begin : g_bad_sec_cnt
    $error("charger_profile_config_regs: SEC_CNT too small");
  end

  logic              rst_meta;
  logic              rst_n;
  logic [15:0]       t32, t43, t54, t65, t76;
  logic [15:0]       vhot, vmid, ihot, imid, en_bits;
  logic [15:0]       absv, abst, eqv, eqt, rech, cvlim;
  logic [15:0]       tchg, tcv, tabs;
  logic              tick;
  logic [2:0]        next_region;
  logic [4:0]        next_vcode, next_icode;
  logic [DATA_W-1:0] next_rdata;
  phase_t            phase;
  phase_t            next_phase;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
    return wr_i && addr_i == ofs;
  endfunction

  function automatic logic [4:0] field(input logic [15:0] r, input int lsb);
    return r[lsb +: FLD_W];
  endfunction

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) t32 <= RST_T32;
    else if (wr_hit(OFS_T32)) t32 <= wdata_i;
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) t43 <= RST_T43;
    else if (wr_hit(OFS_T43)) t43 <= wdata_i;
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) t54 <= RST_T54;
    else if (wr_hit(OFS_T54)) t54 <= wdata_i;
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) t65 <= RST_T65;
    else if (wr_hit(OFS_T65)) t65 <= wdata_i;
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) t76 <= RST_T76;
    else if (wr_hit(OFS_T76)) t76 <= wdata_i;
  end

  // two voltage fields, reserved bits dropped
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) vhot <= RST_VHOT;
    else if (wr_hit(OFS_VHOT)) vhot <= wdata_i & MASK_VHOT;
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) vmid <= RST_VMID;
    else if (wr_hit(OFS_VMID)) vmid <= wdata_i & MASK_VMID;
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) ihot <= RST_IHOT;
    else if (wr_hit(OFS_IHOT)) ihot <= wdata_i & MASK_VHOT;
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) imid <= RST_IMID;
    else if (wr_hit(OFS_IMID)) imid <= wdata_i & MASK_VMID;
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) en_bits <= RST_EN;
    else if (wr_hit(OFS_EN)) en_bits <= wdata_i & MASK_EN;
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) absv <= RST_ABSV;
    else if (wr_hit(OFS_ABSV)) absv <= wdata_i & MASK_ADD;
  end
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) eqv <= RST_EQV;
    else if (wr_hit(OFS_EQV)) eqv <= wdata_i & MASK_ADD;
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      abst  <= RST_ABST;
      eqt   <= RST_EQT;
      rech  <= RST_RECH;
      cvlim <= RST_CVLIM;
    end else begin
      if (wr_hit(OFS_ABST)) abst <= wdata_i;
      if (wr_hit(OFS_EQT)) eqt <= wdata_i;
      if (wr_hit(OFS_RECH)) rech <= wdata_i;
      if (wr_hit(OFS_CVLIM)) cvlim <= wdata_i;
    end
  end

  // region: higher ratio means colder; ties fall to the warmer side
  always_comb begin
    if (ntc_ratio_i > t32)      next_region = 3'h2;
    else if (ntc_ratio_i > t43) next_region = 3'h3;
    else if (ntc_ratio_i > t54) next_region = 3'h4;
    else if (ntc_ratio_i > t65) next_region = 3'h5;
    else if (ntc_ratio_i > t76) next_region = 3'h6;
    else                        next_region = REGION_OFF_HOT;
  end

  // per-region code selection; profile off uses region 4
  always_comb begin
    next_vcode = field(vmid, FLD_HI_LSB);
    next_icode = field(imid, FLD_HI_LSB);
    if (en_bits[EN_PROF_BIT]) begin
      unique case (next_region)
        3'h2: begin
          next_vcode = field(vmid, FLD_LO_LSB);
          next_icode = field(imid, FLD_LO_LSB);
        end
        3'h3: begin
          next_vcode = field(vmid, FLD_MID_LSB);
          next_icode = field(imid, FLD_MID_LSB);
        end
        3'h5: begin
          next_vcode = field(vhot, FLD_LO_LSB);
          next_icode = field(ihot, FLD_LO_LSB);
        end
        3'h6: begin
          next_vcode = field(vhot, FLD_MID_LSB);
          next_icode = field(ihot, FLD_MID_LSB);
        end
        default: begin
          next_vcode = field(vmid, FLD_HI_LSB);
          next_icode = field(imid, FLD_HI_LSB);
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      region_o         <= 3'h4;
      charge_off_o     <= 1'b0;
      vcharge_code_o   <= 5'h00;
      icharge_code_o   <= 5'h00;
      cx_term_en_o     <= 1'b0;
      lead_temp_comp_o <= 1'b0;
    end else begin
      region_o         <= next_region;
      charge_off_o     <= en_bits[EN_PROF_BIT] &&
                          next_region == REGION_OFF_HOT;
      vcharge_code_o   <= next_vcode;
      icharge_code_o   <= next_icode;
      cx_term_en_o     <= en_bits[EN_CX_BIT];
      lead_temp_comp_o <= en_bits[EN_LATC_BIT];
    end
  end

  second_tick #(
    .CYCLES (SEC_CNT)
  ) u_tick (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n),
    .tick_o  (tick)
  );

  // charger phase tracked from the state inputs
  always_comb begin
    if (!charging_i)   next_phase = PH_IDLE;
    else if (absorb_i) next_phase = PH_ABSORB;
    else if (cv_i)     next_phase = PH_CV;
    else               next_phase = PH_CC;
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) phase <= PH_IDLE;
    else phase <= next_phase;
  end

  seconds_counter #(
    .W (DATA_W)
  ) u_tchg (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n),
    .run_i   (lithium_i && phase != PH_IDLE),
    .tick_i  (tick),
    .count_o (tchg)
  );

  seconds_counter #(
    .W (DATA_W)
  ) u_tcv (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n),
    .run_i   (phase == PH_CV),
    .tick_i  (tick),
    .count_o (tcv)
  );

  seconds_counter #(
    .W (DATA_W)
  ) u_tabs (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n),
    .run_i   (!lithium_i && phase == PH_ABSORB),
    .tick_i  (tick),
    .count_o (tabs)
  );

  // timer stop holds until the charge cycle ends; set wins
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) cv_limit_stop_o <= 1'b0;
    else if (lithium_i && phase == PH_CV && tcv >= cvlim)
      cv_limit_stop_o <= 1'b1;
    else if (!charging_i) cv_limit_stop_o <= 1'b0;
  end

  // unmapped and reserved offsets read zero
  always_comb begin
    unique case (addr_i)
      OFS_T32:   next_rdata = t32;
      OFS_T43:   next_rdata = t43;
      OFS_T54:   next_rdata = t54;
      OFS_T65:   next_rdata = t65;
      OFS_T76:   next_rdata = t76;
      OFS_VHOT:  next_rdata = vhot;
      OFS_VMID:  next_rdata = vmid;
      OFS_IHOT:  next_rdata = ihot;
      OFS_IMID:  next_rdata = imid;
      OFS_EN:    next_rdata = en_bits;
      OFS_ABSV:  next_rdata = absv;
      OFS_ABST:  next_rdata = abst;
      OFS_EQV:   next_rdata = eqv;
      OFS_EQT:   next_rdata = eqt;
      OFS_RECH:  next_rdata = rech;
      OFS_TCHG:  next_rdata = tchg;
      OFS_TCV:   next_rdata = tcv;
      OFS_TABS:  next_rdata = tabs;
      OFS_CVLIM: next_rdata = cvlim;
      default:   next_rdata = '0;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) rdata_o <= '0;
    else if (rd_i) rdata_o <= next_rdata;
    else rdata_o <= '0;
  end

  sequence s_wr_thr;
    wr_i && addr_i == OFS_T32;
  endsequence

  property p_thr32;
    @(posedge mclk_i) disable iff (!rst_n)
    s_wr_thr |=> t32 == $past(wdata_i);
  endproperty
  a_thr32: assert property (p_thr32)
    else $error("region 3/2 threshold not written");

  property p_rd_t43;
    @(posedge mclk_i) disable iff (!rst_n)
    rd_i && addr_i == OFS_T43 |=> rdata_o == t43;
  endproperty
  a_rd_t43: assert property (p_rd_t43)
    else $error("region 4/3 threshold readback wrong");

  property p_off;
    @(posedge mclk_i) disable iff (!rst_n)
    en_bits[EN_PROF_BIT] && ntc_ratio_i <= t76 && ntc_ratio_i <= t65
      && ntc_ratio_i <= t54 && ntc_ratio_i <= t43 && ntc_ratio_i <= t32
      |=> charge_off_o && region_o == REGION_OFF_HOT;
  endproperty
  a_off: assert property (p_off)
    else $error("hot region did not stop charging");

  property p_vhot_mask;
    @(posedge mclk_i) disable iff (!rst_n)
    vhot[15:10] == 6'h00 && vmid[15] == 1'b0;
  endproperty
  a_vhot_mask: assert property (p_vhot_mask)
    else $error("voltage reserved bits set");

  property p_region2_codes;
    @(posedge mclk_i) disable iff (!rst_n)
    en_bits[EN_PROF_BIT] && ntc_ratio_i > t32 |=>
      vcharge_code_o == $past(vmid[4:0]) &&
      icharge_code_o == $past(imid[4:0]);
  endproperty
  a_region2_codes: assert property (p_region2_codes)
    else $error("region 2 codes not selected");

  property p_en_mask;
    @(posedge mclk_i) disable iff (!rst_n)
    en_bits[15:3] == 13'h0000 && absv[15:6] == 10'h000;
  endproperty
  a_en_mask: assert property (p_en_mask)
    else $error("reserved config bits set");

  property p_eqv;
    @(posedge mclk_i) disable iff (!rst_n)
    wr_i && addr_i == OFS_EQV |=> eqv == ($past(wdata_i) & MASK_ADD);
  endproperty
  a_eqv: assert property (p_eqv)
    else $error("equalize adder write wrong");

  property p_tcv_clear;
    @(posedge mclk_i) disable iff (!rst_n)
    phase != PH_CV |=> tcv == 16'h0000;
  endproperty
  a_tcv_clear: assert property (p_tcv_clear)
    else $error("cv seconds not cleared outside cv");

  property p_rsvd_read;
    @(posedge mclk_i) disable iff (!rst_n)
    rd_i && addr_i == OFS_RSVD |=> rdata_o == 16'h0000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved offset read nonzero");
endmodule
`default_nettype wire

// ==== hw/charger_profile_pkg.sv ====
// constants for the charger profile register bank
package charger_profile_pkg;
  localparam int          ADDR_W    = 6;
  localparam int          DATA_W    = 16;
  localparam logic [5:0]  OFS_T32   = 6'h20;
  localparam logic [5:0]  OFS_T43   = 6'h21;
  localparam logic [5:0]  OFS_T54   = 6'h22;
  localparam logic [5:0]  OFS_T65   = 6'h23;
  localparam logic [5:0]  OFS_T76   = 6'h24;
  localparam logic [5:0]  OFS_VHOT  = 6'h25;
  localparam logic [5:0]  OFS_VMID  = 6'h26;
  localparam logic [5:0]  OFS_IHOT  = 6'h27;
  localparam logic [5:0]  OFS_IMID  = 6'h28;
  localparam logic [5:0]  OFS_EN    = 6'h29;
  localparam logic [5:0]  OFS_ABSV  = 6'h2A;
  localparam logic [5:0]  OFS_ABST  = 6'h2B;
  localparam logic [5:0]  OFS_EQV   = 6'h2C;
  localparam logic [5:0]  OFS_EQT   = 6'h2D;
  localparam logic [5:0]  OFS_RECH  = 6'h2E;
  localparam logic [5:0]  OFS_RSVD  = 6'h2F;
  localparam logic [5:0]  OFS_TCHG  = 6'h30;
  localparam logic [5:0]  OFS_TCV   = 6'h31;
  localparam logic [5:0]  OFS_TABS  = 6'h32;
  localparam logic [5:0]  OFS_CVLIM = 6'h1D;
  localparam logic [15:0] RST_T32   = 16'h372A;
  localparam logic [15:0] RST_T43   = 16'h1F27;
  localparam logic [15:0] RST_T54   = 16'h1BCC;
  localparam logic [15:0] RST_T65   = 16'h18B9;
  localparam logic [15:0] RST_T76   = 16'h136D;
  localparam logic [15:0] RST_VHOT  = 16'h0000;
  localparam logic [15:0] RST_VMID  = 16'h0000;
  localparam logic [15:0] RST_IHOT  = 16'h01EF;
  localparam logic [15:0] RST_IMID  = 16'h7FEF;
  localparam logic [15:0] RST_EN    = 16'h0000;
  localparam logic [15:0] RST_ABSV  = 16'h0000;
  localparam logic [15:0] RST_ABST  = 16'h0000;
  localparam logic [15:0] RST_EQV   = 16'h002A;
  localparam logic [15:0] RST_EQT   = 16'h0E10;
  localparam logic [15:0] RST_RECH  = 16'h0000;
  localparam logic [15:0] RST_CVLIM = 16'h0000;
  localparam logic [15:0] MASK_VHOT = 16'h03FF;
  localparam logic [15:0] MASK_VMID = 16'h7FFF;
  localparam logic [15:0] MASK_EN   = 16'h0007;
  localparam logic [15:0] MASK_ADD  = 16'h003F;
  localparam int          EN_CX_BIT    = 2;
  localparam int          EN_LATC_BIT  = 1;
  localparam int          EN_PROF_BIT  = 0;
  localparam int          FLD_W        = 5;
  localparam int          FLD_HI_LSB   = 10;
  localparam int          FLD_MID_LSB  = 5;
  localparam int          FLD_LO_LSB   = 0;
  localparam int          CLK_HZ       = 100_000_000;
  localparam int          SECOND_NS    = 1_000_000_000;
  localparam int          CLK_NS       = 10;
  localparam int          SEC_CYCLES   = SECOND_NS / CLK_NS;
  localparam logic [2:0]  REGION_OFF_COLD = 3'h1;
  localparam logic [2:0]  REGION_OFF_HOT  = 3'h7;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_CC     = 2'b01,
    PH_CV     = 2'b11,
    PH_ABSORB = 2'b10
  } phase_t;
endpackage

// ==== hw/second_tick.sv ====
// one-cycle enable once per second from the system clock
`timescale 1ns/100ps
`default_nettype none
module second_tick
  import charger_profile_pkg::*;
#(
  parameter int CYCLES = SEC_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  if (CYCLES < 2) begin : g_bad_cycles
    $error("second_tick: CYCLES must be at least 2");
  end

  logic [31:0] cnt;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt == 32'(CYCLES - 1)) begin
      cnt    <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== hw/seconds_counter.sv ====
// saturating seconds counter, cleared whenever its phase is left
`timescale 1ns/100ps
`default_nettype none
module seconds_counter
  import charger_profile_pkg::*;
#(
  parameter int W = DATA_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         run_i,
  input  wire logic         tick_i,
  output logic      [W-1:0] count_o
);
  if (W < 1) begin : g_bad_width
    $error("seconds_counter: W must be positive");
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
    end else if (!run_i) begin
      count_o <= '0;
    end else if (tick_i && count_o != {W{1'b1}}) begin
      count_o <= count_o + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/charger_profile_config_regs_tb.sv ====
// self-checking bench for the charger profile register bank
`timescale 1ns/100ps
`default_nettype none
module charger_profile_config_regs_tb
  import charger_profile_pkg::*;
;
  // short second so the phase timers move within a few tens of cycles
  localparam int SEC = 10;

  logic        mclk_i;
  logic        resetn_i;
  logic [5:0]  addr_i;
  logic [15:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [15:0] ntc_ratio_i;
  logic        lithium_i;
  logic        charging_i;
  logic        cv_i;
  logic        absorb_i;
  logic [15:0] rdata_o;
  logic [2:0]  region_o;
  logic        charge_off_o;
  logic [4:0]  vcharge_code_o;
  logic [4:0]  icharge_code_o;
  logic        cx_term_en_o;
  logic        lead_temp_comp_o;
  logic        cv_limit_stop_o;
  int          num_errors;
  int          check_count;
  logic [15:0] v;
  logic [15:0] rst_tab [19] = '{16'h372A, 16'h1F27, 16'h1BCC, 16'h18B9,
    16'h136D, 16'h0000, 16'h0000, 16'h01EF, 16'h7FEF, 16'h0000, 16'h0000,
    16'h0000, 16'h002A, 16'h0E10, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000};
  // value read back after writing all ones: only active bits stick
  logic [15:0] ones_tab [19] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'h03FF, 16'h7FFF, 16'h03FF, 16'h7FFF, 16'h0007, 16'h003F,
    16'hFFFF, 16'h003F, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000,
    16'h0000};
  logic [15:0] ntc_tab [9] = '{16'hFFFF, 16'h372B, 16'h372A, 16'h1F28,
    16'h1F27, 16'h1BCC, 16'h18B9, 16'h136D, 16'h0000};
  logic [2:0]  reg_tab [9] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h6,
    3'h7, 3'h7};

  charger_profile_config_regs #(.SEC_CNT(SEC)) dut (
    .mclk_i           (mclk_i),
    .resetn_i         (resetn_i),
    .addr_i           (addr_i),
    .wdata_i          (wdata_i),
    .wr_i             (wr_i),
    .rd_i             (rd_i),
    .ntc_ratio_i      (ntc_ratio_i),
    .lithium_i        (lithium_i),
    .charging_i       (charging_i),
    .cv_i             (cv_i),
    .absorb_i         (absorb_i),
    .rdata_o          (rdata_o),
    .region_o         (region_o),
    .charge_off_o     (charge_off_o),
    .vcharge_code_o   (vcharge_code_o),
    .icharge_code_o   (icharge_code_o),
    .cx_term_en_o     (cx_term_en_o),
    .lead_temp_comp_o (lead_temp_comp_o),
    .cv_limit_stop_o  (cv_limit_stop_o)
  );

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_span(input logic [15:0] got, input int lo, input int hi);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      num_errors++;
      $display("[FAIL] %0t timer %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic phase(input logic li, input logic ch, input logic c,
                       input logic ab);
    @(posedge mclk_i);
    lithium_i  <= li;
    charging_i <= ch;
    cv_i       <= c;
    absorb_i   <= ab;
  endtask

  task automatic set_ntc(input logic [15:0] r);
    @(posedge mclk_i);
    ntc_ratio_i <= r;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask

  task automatic release_reset();
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic chk_resets();
    for (int i = 0; i < 19; i++) begin
      rd(6'h20 + 6'(i), v);
      chk_rd(v, rst_tab[i]); // reset
    end
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    $display("[FAIL] %0t run did not finish", $time);
    give_verdict();
  end

  initial begin
    num_errors  = 0;
    check_count = 0;
    resetn_i    = 1'b0;
    addr_i      = 6'h00;
    wdata_i     = 16'h0000;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    ntc_ratio_i = 16'h0000;
    lithium_i   = 1'b0;
    charging_i  = 1'b0;
    cv_i        = 1'b0;
    absorb_i    = 1'b0;
    release_reset();
    chk_resets();
    // a nonzero read first, so the idle check below can see it drop
    rd(OFS_T32, v);
    chk_rd(v, RST_T32); // reset value
    @(posedge mclk_i);
    #1;
    chk_rd(rdata_o, 16'h0000); // read data stands one cycle
    rd(OFS_CVLIM, v);
    chk_rd(v, 16'h0000); // limit resets to zero
    // all ones at 0x20 to 0x32 and 0x00, including read-only, reserved and unmapped places
    for (int i = 0; i < 19; i++) begin
      wr(6'h20 + 6'(i), 16'hFFFF);
    end
    wr(6'h00, 16'hFFFF);
    for (int i = 0; i < 19; i++) begin
      rd(6'h20 + 6'(i), v);
      chk_rd(v, ones_tab[i]); // mask
    end
    rd(6'h00, v);
    chk_rd(v, 16'h0000); // unmapped offset
    // a second reset in mid-run must restore the defaults
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    release_reset();
    chk_resets();
    // codes chosen so region r gives voltage r and current 0x10+r
    wr(OFS_VHOT, 16'h00C5);
    wr(OFS_VMID, 16'h1062);
    wr(OFS_IHOT, 16'h02D5);
    wr(OFS_IMID, 16'h5272);
    wr(OFS_EN, 16'h0001);
    for (int i = 0; i < 9; i++) begin
      set_ntc(ntc_tab[i]);
      chk_out(16'(region_o), 16'(reg_tab[i])); // region borders
      chk_out(16'(charge_off_o), 16'(reg_tab[i] == 3'h7)); // off
      if (reg_tab[i] != 3'h7) begin
        chk_out(16'(vcharge_code_o), 16'(reg_tab[i])); // field
        chk_out(16'(icharge_code_o), 16'h10 + 16'(reg_tab[i]));
      end
    end
    // profile off: region 4 codes and no shutdown even when very hot
    wr(OFS_EN, 16'h0004);
    set_ntc(16'h0000);
    chk_out(16'(charge_off_o), 16'h0000); // profile disabled
    chk_out(16'(vcharge_code_o), 16'h0004); // region 4 voltage
    chk_out(16'(icharge_code_o), 16'h0014); // region 4 current
    chk_out(16'(cx_term_en_o), 16'h0001); // bit 2
    chk_out(16'(lead_temp_comp_o), 16'h0000); // bit 1 clear
    wr(OFS_EN, 16'h0002);
    set_ntc(16'h0000);
    chk_out(16'(cx_term_en_o), 16'h0000); // bit 2 clear
    chk_out(16'(lead_temp_comp_o), 16'h0001); // bit 1
    // lithium in constant voltage with a limit of three seconds
    wr(OFS_CVLIM, 16'h0003);
    rd(OFS_CVLIM, v);
    chk_rd(v, 16'h0003); // limit written
    phase(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (5) @(posedge mclk_i);
    #1;
    chk_out(16'(cv_limit_stop_o), 16'h0000); // below limit
    repeat (45) @(posedge mclk_i);
    rd(OFS_TCHG, v);
    chk_span(v, 4, 6); // total charge seconds
    rd(OFS_TCV, v);
    chk_span(v, 4, 6); // constant voltage seconds
    chk_out(16'(cv_limit_stop_o), 16'h0001); // limit reached
    phase(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge mclk_i);
    #1;
    chk_out(16'(cv_limit_stop_o), 16'h0000); // cleared off charge
    rd(OFS_TCHG, v);
    chk_rd(v, 16'h0000); // cleared when not charging
    // other chemistry in absorb: only the absorb timer runs, no stop
    phase(1'b0, 1'b1, 1'b1, 1'b1);
    repeat (50) @(posedge mclk_i);
    rd(OFS_TABS, v);
    chk_span(v, 4, 6); // absorb seconds
    rd(OFS_TCHG, v);
    chk_rd(v, 16'h0000); // lithium only
    rd(OFS_TCV, v);
    chk_rd(v, 16'h0000); // absorb takes priority
    chk_out(16'(cv_limit_stop_o), 16'h0000); // lithium only
    // lithium in constant current: only the total charge timer runs
    phase(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (50) @(posedge mclk_i);
    rd(OFS_TCHG, v);
    chk_span(v, 4, 6); // runs in constant current
    rd(OFS_TCV, v);
    chk_rd(v, 16'h0000); // not in constant voltage
    rd(OFS_TABS, v);
    chk_rd(v, 16'h0000); // not for lithium
    give_verdict();
  end
endmodule
`default_nettype wire
